// ### pit_pkg.sv
// Package with register map, field layout, codes and carriers
package pit_pkg;

   // Register offsets
   localparam logic [7:0] PIT_ADDR_MASK     = 8'h03;
   localparam logic [7:0] PIT_ADDR_TXSTATE  = 8'h04;
   localparam logic [7:0] PIT_ADDR_SETUP    = 8'h05;

   // Transmit state field positions
   localparam int PIT_TM_LSB    = 0;
   localparam int PIT_IC_LO_BIT = 3;
   localparam int PIT_IC_HI_BIT = 4;
   localparam int PIT_SE_BIT    = 5;
   localparam int PIT_PE_BIT    = 6;
   localparam int PIT_SPARE_BIT = 7;

   // Reset values
   localparam logic [7:0] PIT_MASK_RST    = 8'h00;
   localparam logic [7:0] PIT_TXSTATE_RST = 8'hA2;
   localparam logic [7:0] PIT_SETUP_RST   = 8'h00;

   // Line symbol pairs, two 5-bit symbols
   localparam logic [9:0] PIT_SYM_IDLE  = 10'h3FF;
   localparam logic [9:0] PIT_SYM_QUIET = 10'h000;
   localparam logic [9:0] PIT_SYM_HQ    = 10'h080;
   localparam logic [9:0] PIT_SYM_HALT  = 10'h084;

   // Transmit pattern select codes
   typedef enum logic [2:0] {
      PIT_PASS_THROUGH_MODE  = 3'h0,
      PIT_IDLE_FILL_MODE     = 3'h1,
      PIT_QUIET_DISABLE_MODE = 3'h2,
      PIT_RSVD3_MODE         = 3'h3,
      PIT_HALT_QUIET_MODE    = 3'h4,
      PIT_HALT_FILL_MODE     = 3'h5,
      PIT_QUIET_FILL_MODE    = 3'h6,
      PIT_RSVD7_MODE         = 3'h7
   } pit_tx_mode_t;

   // Injection control codes
   typedef enum logic [1:0] {
      PIT_INJ_NONE     = 2'h0,
      PIT_INJ_ONE_SHOT = 2'h1,
      PIT_INJ_PERIODIC = 2'h2,
      PIT_INJ_CONT     = 2'h3
   } pit_inj_mode_t;

   // Interrupt condition flags, bit order of the mask
   typedef struct packed {
      logic user_irq_flag;
      logic receive_group_b_flag;
      logic receive_group_a_flag;
      logic link_error_limit_flag;
      logic write_inhibit_flag;
      logic write_reject_flag;
      logic bus_parity_error_flag;
      logic request_parity_error_flag;
   } pit_flags_t;

   // Transmit state register layout
   typedef struct packed {
      logic         spare_bit7;
      logic         request_parity_enable;
      logic         smoother_on;
      logic         inject_select_hi;
      logic         inject_select_lo;
      pit_tx_mode_t transmit_pattern_select;
   } pit_txstate_t;

   // Management port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pit_bus_req_t;

endpackage

// ### pit_tx_select.sv
// Transmit symbol selector with injection over modes over smoother
`timescale 1ns/100ps
module pit_tx_select (
   input  wire logic                  clk_in,       // Symbol clock
   input  wire logic                  reset_n_in,   // Sync reset, low
   input  wire pit_pkg::pit_txstate_t state_in,     // Transmit state
   input  wire logic                  stop_in,      // Stop mode
   input  wire logic                  inject_in,    // Inject this pair
   input  wire logic [9:0]            inject_sym_in,// Injection pair
   input  wire logic [9:0]            request_in,   // Request data pair
   input  wire logic [9:0]            smooth_in,    // Smoother output
   output      logic [9:0]            txd_out,      // Line symbol pair
   output      logic                  tx_en_out     // Transmitter enable
);
   import pit_pkg::*;

   logic [9:0] sym_d;
   logic       en_d;

   // Priority: stop, then injection, then forced mode, then filter path
   always_comb begin
      en_d  = 1'b1;
      sym_d = PIT_SYM_QUIET;
      if (stop_in) begin
         en_d  = 1'b0;                     // RL10
         sym_d = PIT_SYM_QUIET;
      end else if (inject_in) begin
         sym_d = inject_sym_in;            // RL8
      end else begin
         case (state_in.transmit_pattern_select)
            PIT_PASS_THROUGH_MODE: begin
               // Smoother only shapes the stream when enabled
               sym_d = state_in.smoother_on ? smooth_in
                                            : request_in; // RL12 RL20
            end
            PIT_IDLE_FILL_MODE:     sym_d = PIT_SYM_IDLE;  // RL13
            PIT_QUIET_DISABLE_MODE: begin
               sym_d = PIT_SYM_QUIET;                      // RL14
               en_d  = 1'b0;
            end
            PIT_HALT_QUIET_MODE:    sym_d = PIT_SYM_HQ;    // RL15
            PIT_HALT_FILL_MODE:     sym_d = PIT_SYM_HALT;  // RL16
            PIT_QUIET_FILL_MODE:    sym_d = PIT_SYM_QUIET; // RL16
            default:                sym_d = PIT_SYM_QUIET; // RL17
         endcase
      end
   end

   // Registered line outputs, quiet and disabled out of reset
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         txd_out   <= PIT_SYM_QUIET;
         tx_en_out <= 1'b0;
      end else begin
         txd_out   <= sym_d;
         tx_en_out <= en_d;
      end
   end

endmodule

// ### pit_regs.sv
// Interrupt mask and transmit state registers with trigger load
//
// What this block does
// [RL1] Interrupt output low when any flag and its mask bit are both one.
// [RL2] Reset clears the whole interrupt mask, masking every source.
// [RL3] Mask bits 0..3 gate parity, bus parity, reject, inhibit flags.
// [RL4] Mask bits 4..7 gate link error, group A, group B, user flags.
// [RL5] Mask at 03h always read/write; transmit state at 04h conditional.
// [RL6] Trigger loads transmit state with preprogrammed mode from setup.
// [RL7] Transmit state writes blocked during trigger copy; each sets the reject flag.
// [RL8] Output priority: injection, then forced modes, then smoother.
// [RL9] Reset loads mode 010, smoother on, bit 7 set, rest zero.
// [RL10] In stop mode transmit state has no effect on the transmitter.
// [RL11] Layout: parity enable 6, smoother 5, injection 4:3, mode 2:0.
// [RL12] Mode 000 passes request data through unchanged; here only with smoother off, else it sends the smoother output.
// [RL13] Mode 001 sends Idle pairs 11111 11111.
// [RL14] Mode 010 sends Quiet pairs and drops transmitter enable.
// [RL15] Mode 100 sends Halt Quiet pairs 00100 00000.
// [RL16] Mode 101 sends Halt pairs; mode 110 sends Quiet pairs.
// [RL17] Reserved modes 011 and 111 send Quiet pairs.
// [RL18] Injection 00 none, 01 one shot, 10 periodic, 11 continuous.
// [RL19] One shot done clears low injection bit as acknowledgement.
// [RL20] Smoother redistributes idles only while its enable is one.
// [RL21] Interrupt output recomputed every clock from flags and mask.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module pit_regs (
   input  wire logic                clk_in,          // Symbol clock
   input  wire logic                reset_n_in,      // Sync reset, low
   input  wire logic [7:0]          addr_in,         // Register address
   input  wire logic [7:0]          wdata_in,        // Write data
   input  wire logic                wr_in,           // Write strobe
   input  wire logic                rd_in,           // Read strobe
   output      logic [7:0]          rdata_out,       // Read data
   input  wire pit_pkg::pit_flags_t flags_in,        // Condition flags
   input  wire logic                trigger_in,      // Trigger event
   input  wire logic                stop_in,         // Stop mode
   input  wire logic                jk_in,           // JK pair seen
   input  wire logic [7:0]          inject_count_in, // Injection spacing
   input  wire logic [9:0]          inject_sym_in,   // Injection pair
   input  wire logic [9:0]          request_in,      // Request data pair
   input  wire logic [9:0]          smooth_in,       // Smoother output
   output      logic                write_reject_out,// Reject event pulse
   output      logic                irq_n_out,       // Interrupt, low
   output      pit_pkg::pit_txstate_t state_out,     // Transmit state
   output      logic [9:0]          txd_out,         // Line symbol pair
   output      logic                tx_en_out        // Transmitter enable
);
   import pit_pkg::*;

   pit_bus_req_t  req;
   logic [7:0]    mask_q;
   pit_txstate_t  txstate_q;
   logic [7:0]    setup_q;
   logic          copy_q;
   logic          wr_mask;
   logic          wr_tx;
   logic          wr_setup;
   logic          inject_now;
   logic [7:0]    gap_q;
   logic          armed_q;
   logic          oneshot_done;
   logic [1:0]    ic;

   // Decode one register address against the request
   function automatic logic hit(input pit_bus_req_t r,
                                input logic [7:0] a);
      hit = (r.addr == a);
   endfunction

   assign req      = '{addr: addr_in, wdata: wdata_in,
                       wr: wr_in, rd: rd_in};
   assign wr_mask  = req.wr && hit(req, PIT_ADDR_MASK);      // RL5
   assign wr_setup = req.wr && hit(req, PIT_ADDR_SETUP);
   // Writes lose against the copy so the trigger state is never torn
   assign wr_tx    = req.wr && hit(req, PIT_ADDR_TXSTATE)
                     && !copy_q;                             // RL7
   assign ic       = {txstate_q.inject_select_hi,
                      txstate_q.inject_select_lo};

   // Interrupt mask register
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         mask_q <= PIT_MASK_RST;                             // RL2
      end else if (wr_mask) begin
         mask_q <= wdata_in;                                 // RL5
      end
   end

   // Trigger setup register holding the preprogrammed mode
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         setup_q <= PIT_SETUP_RST;
      end else if (wr_setup) begin
         setup_q <= wdata_in;
      end
   end

   // Copy window: one cycle after the trigger the copy lands
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         copy_q <= 1'b0;
      end else begin
         copy_q <= trigger_in;                               // RL6
      end
   end

   // Reject pulse for each transmit state write attempted during the copy
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         write_reject_out <= 1'b0;
      end else begin
         write_reject_out <= req.wr && hit(req, PIT_ADDR_TXSTATE)
                             && copy_q;                      // RL7
      end
   end

   // Transmit state register; copy beats one-shot clear beats write
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         txstate_q <= PIT_TXSTATE_RST;                       // RL9
      end else if (copy_q) begin
         txstate_q.transmit_pattern_select <=
            pit_tx_mode_t'(setup_q[2:0]);                    // RL6
      end else if (wr_tx) begin
         txstate_q <= pit_txstate_t'(wdata_in);              // RL11
         if (oneshot_done) begin
            txstate_q.inject_select_lo <= 1'b0;              // RL19
         end
      end else if (oneshot_done) begin
         txstate_q.inject_select_lo <= 1'b0;                 // RL19
      end
   end

   // Injection spacing counter restarted by each JK pair
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         gap_q   <= 8'h00;
         armed_q <= 1'b0;
      end else if (jk_in) begin
         gap_q   <= 8'h00;
         armed_q <= (ic == PIT_INJ_ONE_SHOT);
      end else if (gap_q == inject_count_in) begin
         gap_q   <= 8'h00;
         armed_q <= 1'b0;
      end else begin
         gap_q   <= gap_q + 8'h01;
      end
   end

   // Injection decision per mode
   always_comb begin
      case (pit_inj_mode_t'(ic))
         PIT_INJ_NONE:     inject_now = 1'b0;                // RL18
         PIT_INJ_ONE_SHOT: inject_now =
            (inject_count_in == 8'h00) ? jk_in
                                       : (armed_q && !jk_in &&
                                          gap_q == inject_count_in);
         PIT_INJ_PERIODIC: inject_now =
            (inject_count_in == 8'h00) ||
            (gap_q == inject_count_in);
         PIT_INJ_CONT:     inject_now = 1'b1;                // RL18
         default:          inject_now = 1'b0;
      endcase
   end
   assign oneshot_done = (ic == PIT_INJ_ONE_SHOT) && inject_now
                         && !stop_in;

   // Interrupt output from current flags and mask each clock
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         irq_n_out <= 1'b1;
      end else begin
         irq_n_out <= ~|(flags_in & mask_q);        // RL1 RL3 RL4 RL21
      end
   end

   // Read data valid the cycle after the strobe; unmapped read zero
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rdata_out <= 8'h00;
      end else if (req.rd) begin
         if (hit(req, PIT_ADDR_MASK)) begin
            rdata_out <= mask_q;
         end else if (hit(req, PIT_ADDR_TXSTATE)) begin
            rdata_out <= txstate_q;                          // RL5
         end else if (hit(req, PIT_ADDR_SETUP)) begin
            rdata_out <= setup_q;
         end else begin
            rdata_out <= 8'h00;
         end
      end else begin
         rdata_out <= 8'h00;
      end
   end

   assign state_out = txstate_q;

   // Transmit path selection
   pit_tx_select u_tx (
      .clk_in        (clk_in),
      .reset_n_in    (reset_n_in),
      .state_in      (txstate_q),
      .stop_in       (stop_in),
      .inject_in     (inject_now),
      .inject_sym_in (inject_sym_in),
      .request_in    (request_in),
      .smooth_in     (smooth_in),
      .txd_out       (txd_out),
      .tx_en_out     (tx_en_out)
   );

endmodule

// ### pit_pmd_model.sv
// Line-side transceiver model that sees the transmitted pairs
`timescale 1ns/100ps
module pit_pmd_model (
   input  wire logic       clk_in,   // Symbol clock
   input  wire logic [9:0] txd_in,   // Line pair
   input  wire logic       tx_en_in, // Driver enable
   output      logic [9:0] line_out  // Pair on the medium
);
   // A disabled driver sends no light, so the medium reads as quiet
   always_ff @(posedge clk_in) begin
      line_out <= tx_en_in ? txd_in : 10'h000;
   end
endmodule

// ### pit_regs_chk.sv
// Port-level assertions for the mask and transmit state registers
`timescale 1ns/100ps
module pit_regs_chk
   import pit_pkg::*;
(
   input wire logic                  clk_in,           // Clock
   input wire logic                  reset_n_in,       // Reset, low
   input wire logic [7:0]            addr_in,          // Address
   input wire logic                  wr_in,            // Write strobe
   input wire pit_pkg::pit_flags_t   flags_in,         // Flags
   input wire logic                  trigger_in,       // Trigger
   input wire logic                  stop_in,          // Stop mode
   input wire logic [9:0]            inject_sym_in,    // Injection pair
   input wire logic [9:0]            request_in,       // Request pair
   input wire logic                  write_reject_out, // Reject pulse
   input wire logic                  irq_n_out,        // Interrupt, low
   input wire pit_pkg::pit_txstate_t state_out,        // Transmit state
   input wire logic [9:0]            txd_out,          // Line pair
   input wire logic                  tx_en_out         // Driver enable
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   // Reset leaves the line off, smoother on and spare bit set
   rst_state_a: assert property (!$past(reset_n_in) |->
      state_out == 8'hA2) else $error("transmit state reset wrong");
   // All sources masked straight after reset
   rst_mask_a: assert property (!$past(reset_n_in) |=> irq_n_out)
      else $error("interrupt not masked after reset");
   // No flag up means no interrupt one cycle on
   no_flag_a: assert property (flags_in == 8'h00 |=> irq_n_out)
      else $error("interrupt without a flag");
   // A write landing in the copy cycle is reported by a reject pulse
   reject_a: assert property (trigger_in ##1
      (wr_in && addr_in == PIT_ADDR_TXSTATE) |=> write_reject_out)
      else $error("blocked write not reported");
   // A reject pulse needs a write one cycle after a trigger
   reject_src_a: assert property (write_reject_out |->
      $past(wr_in) && $past(trigger_in, 2)) else $error("spurious reject");
   // Stop overrides the register: quiet line, driver off
   stop_a: assert property ($past(stop_in) |->
      txd_out == PIT_SYM_QUIET && !tx_en_out) else $error("stop ignored");
   // Idle pattern without injection
   idle_a: assert property (state_out[4:0] == 5'h01 && !stop_in |=>
      txd_out == 10'h3FF) else $error("idle pattern wrong");
   // Off, quiet and reserved codes all give quiet pairs
   quiet_a: assert property (state_out[4:3] == 2'h0 && state_out[1]
      && !stop_in |=> txd_out == 10'h000) else $error("pattern not quiet");
   // Off code drops the driver enable
   off_a: assert property (state_out[4:0] == 5'h02 |=> !tx_en_out)
      else $error("driver left on");
   // Pass-through with smoother off forwards request data
   pass_a: assert property (state_out[5:0] == 6'h00 && !stop_in |=>
      txd_out == $past(request_in)) else $error("request not passed");
   // Halt based codes give their fixed pairs
   hq_a: assert property (state_out[4:0] == 5'h04 && !stop_in |=>
      txd_out == PIT_SYM_HQ) else $error("halt quiet pattern wrong");
   halt_a: assert property (state_out[4:0] == 5'h05 && !stop_in |=>
      txd_out == PIT_SYM_HALT) else $error("halt pattern wrong");
   // Continuous injection beats every pattern
   inject_a: assert property (state_out[4:3] == 2'h3 && !stop_in |=>
      txd_out == $past(inject_sym_in)) else $error("injection lost");
endmodule

bind pit_regs pit_regs_chk i_chk (
   .clk_in, .reset_n_in, .addr_in, .wr_in, .flags_in, .trigger_in,
   .stop_in, .inject_sym_in, .request_in, .write_reject_out,
   .irq_n_out, .state_out, .txd_out, .tx_en_out
);

// ### tb_top.sv
// Directed bench for the mask and transmit state registers
`timescale 1ns/100ps
module tb_top;
   import pit_pkg::*;
   localparam logic [9:0] req_sym = 10'h155; // Fixed line inputs
   localparam logic [9:0] smo_sym = 10'h2AA;
   localparam logic [9:0] inj_sym = 10'h0F3;
   logic         clk_in = 1'b0;
   logic         reset_n_in = 1'b0;
   logic [7:0]   addr = 8'h00;
   logic [7:0]   wdata = 8'h00;
   logic         wr = 1'b0;
   logic         rd = 1'b0;
   logic         trig = 1'b0;
   logic         stop = 1'b0;
   logic         jk = 1'b0;
   pit_flags_t   flags = 8'h00;
   logic [7:0]   rdata;
   logic         rej;
   logic         irq_n;
   logic         tx_en;
   pit_txstate_t state;
   logic [9:0]   txd;
   logic [9:0]   line;
   logic [9:0]   exp_sym [8];
   int           bad_count = 0;
   int           compares = 0;
   int           cyc = 0;

   // Symbol clock, 25 ns
   always #12.5 clk_in = ~clk_in;

   pit_regs i_dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .flags_in(flags), .trigger_in(trig), .stop_in(stop), .jk_in(jk),
      .inject_count_in(8'h00), .inject_sym_in(inj_sym),
      .request_in(req_sym), .smooth_in(smo_sym),
      .write_reject_out(rej), .irq_n_out(irq_n), .state_out(state),
      .txd_out(txd), .tx_en_out(tx_en)
   );
   pit_pmd_model i_pmd (
      .clk_in(clk_in), .txd_in(txd), .tx_en_in(tx_en), .line_out(line)
   );

   task automatic end_of_test();
      $display("Mismatches %0d, comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One write cycle; a pending trigger pulse also ends here
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      trig <= 1'b0;
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 cmp8(rdata, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // Cut a hang short
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      exp_sym = '{req_sym, 10'h3FF, 10'h000, 10'h000,
                  10'h080, 10'h084, 10'h000, 10'h000};
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1'b1;
      // Reset values, and silence at an unmapped place
      rd_reg(PIT_ADDR_MASK, 8'h00);
      rd_reg(PIT_ADDR_TXSTATE, 8'hA2);
      rd_reg(8'h7E, 8'h00);
      cmp8({7'h00, tx_en}, 8'h00);
      wr_reg(PIT_ADDR_MASK, 8'h5A);
      rd_reg(PIT_ADDR_MASK, 8'h5A);
      // Each flag against all other mask bits, then its own
      for (int i = 0; i < 8; i++) begin
         wr_reg(PIT_ADDR_MASK, ~(8'h01 << i));
         flags <= pit_flags_t'(8'h01 << i);
         tick(2);
         cmp8({7'h00, irq_n}, 8'h01);
         wr_reg(PIT_ADDR_MASK, 8'h01 << i);
         tick(2);
         cmp8({7'h00, irq_n}, 8'h00);
      end
      wr_reg(PIT_ADDR_MASK, 8'h00);
      flags <= 8'h00;
      // Every pattern code, smoother and injection off
      for (int m = 0; m < 8; m++) begin
         wr_reg(PIT_ADDR_TXSTATE, 8'(m));
         tick(4);
         cmp10(txd, exp_sym[m]);
         cmp10(line, exp_sym[m]);
         if (m < 3) cmp8({7'h00, tx_en}, {7'h00, m != 2});
      end
      // Smoother path, then periodic and continuous injection over idle
      wr_reg(PIT_ADDR_TXSTATE, 8'h20);
      tick(3);
      cmp10(txd, smo_sym);
      for (int ic = 2; ic < 4; ic++) begin
         wr_reg(PIT_ADDR_TXSTATE, 8'(ic * 8 + 1));
         tick(3);
         cmp10(txd, inj_sym);
      end
      // One shot fires on the JK pair and clears its own low bit
      wr_reg(PIT_ADDR_TXSTATE, 8'h09);
      jk <= 1'b1;
      @(posedge clk_in);
      jk <= 1'b0;
      #1 cmp10(txd, inj_sym);
      tick(3);
      rd_reg(PIT_ADDR_TXSTATE, 8'h01);
      // Stop mode silences the line over the idle pattern
      wr_reg(PIT_ADDR_TXSTATE, 8'h01);
      stop <= 1'b1;
      tick(3);
      cmp10(txd, 10'h000);
      cmp8({7'h00, tx_en}, 8'h00);
      @(posedge clk_in);
      stop <= 1'b0;
      // Trigger copies the setup mode; a write in the copy cycle fails
      wr_reg(PIT_ADDR_SETUP, 8'h05);
      wr_reg(PIT_ADDR_TXSTATE, 8'h22);
      trig <= 1'b1;
      wr_reg(PIT_ADDR_TXSTATE, 8'h61);
      #1 cmp8({7'h00, rej}, 8'h01);
      rd_reg(PIT_ADDR_TXSTATE, 8'h25);
      // Full layout readback, then a mid-run reset restores both
      wr_reg(PIT_ADDR_TXSTATE, 8'hE2);
      rd_reg(PIT_ADDR_TXSTATE, 8'hE2);
      wr_reg(PIT_ADDR_MASK, 8'hFF);
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      tick(2);
      reset_n_in <= 1'b1;
      rd_reg(PIT_ADDR_MASK, 8'h00);
      rd_reg(PIT_ADDR_TXSTATE, 8'hA2);
      cmp8({7'h00, tx_en}, 8'h00);
      end_of_test();
   end
endmodule
